// ### common/sbp_pkg.sv
// Purpose: Constants and types shared by the bridge PWM current regulator.
// Assumes: Master oscillator tick arrives as a one-cycle enable pulse.
// Notes: All timing counts are in master oscillator cycles.
`default_nettype none

package sbp_pkg;

    // ==========================================================
    // Oscillator and timing
    // ==========================================================
    localparam int unsigned CLK_HZ = 40000000;  // System clock rate
    localparam int unsigned OSC_HZ = 4000000;   // Nominal oscillator rate
    localparam logic [6:0] OFF_CYC = 7'h57;     // Off period, 87 cycles
    localparam logic [6:0] BLANK_CYC = 7'h06;   // Blanking, 6 cycles
    localparam logic [6:0] DEAD_CYC = 7'h03;    // Dead time, 3 cycles

    // Fast decay portions for the four fraction selector codes
    localparam logic [6:0] FD_FRAC0 = 7'h00;    // 0 percent
    localparam logic [6:0] FD_FRAC1 = 7'h0d;    // Small portion
    localparam logic [6:0] FD_FRAC2 = 7'h22;    // Larger portion
    localparam logic [6:0] FD_FRAC3 = 7'h57;    // 100 percent

    // ==========================================================
    // Translator
    // ==========================================================
    localparam logic [5:0] HOME_POS = 6'h08;    // 45 degree home index
    localparam logic [7:0] REF_DIV_SHIFT = 8'h03; // Divide by eight

    // Per-bridge regulator phase
    typedef enum logic [2:0] {
        SBP_IDLE = 3'b000,   // Off, sleeping, faulted or locked out
        SBP_DEAD = 3'b001,   // Dead time before drive
        SBP_BLANK = 3'b010,  // Driving, comparator blanked
        SBP_DRIVE = 3'b011,  // Driving, comparator armed
        SBP_OFF = 3'b100     // Decay period
    } sbp_phase_t;

endpackage : sbp_pkg

`default_nettype wire

// ### rtl/sbp_bridge_pwm.sv
// Purpose: Two fixed off-time PWM current regulators with translator.
// Assumes: Inputs synchronous to mclk_i; comparators are digital levels.
// Notes: Gate outputs per bridge: [0]=high A,[1]=low A,[2]=high B,[3]=low B.
`default_nettype none

// Summary of operation
// - Each bridge drives diagonal until comparator trips
// - Slow decay drops source; fast drops both
// - Trip level is reference/8 times step percent
// - Off period lasts 87 oscillator cycles
// - Comparator ignored 6 cycles after switching
// - Three cycle dead time before complementary on
// - Output disable high forces every transistor off
// - Translator runs regardless of output disable
// - Reset low sleeps; release starts at home
// - Short reset pulse returns to home
// - Slow when rising, mixed when falling
// - Mixed: fast for selected cycles, then slow
// - Zero percent fraction means always slow
// - Full fraction means whole off fast
// - Mixed decay also just after zero crossing
// - Active rectification turns on decay transistors
// - Zero current detect stops rectification
// - Rectify disable high leaves diodes only
// - Faults hold transistors off until cleared
// - Supply low holds off; recovery resets home
// - Step rising edge advances translator increment
// - Resolution inputs sampled at step edge
// - Periods counted in oscillator cycles
module sbp_bridge_pwm (
    input wire logic mclk_i,                      // System clock
    input wire logic nrst_i,                      // Async reset, low
    input wire logic osc_tick_i,                  // Oscillator cycle pulse
    input wire logic sleep_n_i,                   // Device reset/sleep, low
    input wire logic out_disable_i,               // Output disable, high
    input wire logic step_i,                      // Step input
    input wire logic dir_i,                       // Direction input
    input wire logic microstep_res_sel_a_i,       // Resolution select a
    input wire logic microstep_res_sel_b_i,       // Resolution select b
    input wire logic fast_decay_fraction_sel_a_i, // Fast fraction a
    input wire logic fast_decay_fraction_sel_b_i, // Fast fraction b
    input wire logic sync_rectify_disable_i,      // Rectify disable, high
    input wire logic [7:0] ref_level_i,           // External reference
    input wire logic [1:0] current_shunt_trip_i,  // Sense compare per bridge
    input wire logic [1:0] zero_current_i,        // Zero current per bridge
    input wire logic over_temp_i,                 // Overtemperature fault
    input wire logic gate_regulator_rail_low_i,   // Gate rail undervoltage
    input wire logic supply_low_lockout_i,        // Logic supply low
    output logic [3:0] gate1_o,                   // Bridge 1 gates
    output logic [3:0] gate2_o,                   // Bridge 2 gates
    output logic [7:0] trip_ref1_o,               // Bridge 1 trip level
    output logic [7:0] trip_ref2_o,               // Bridge 2 trip level
    output logic [5:0] position_o,                // Translator index
    output logic home_o                           // At home position
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic step_d;                       // Previous step level
        logic [5:0] pos;                    // Index 0..63 per electrical turn
        logic [1:0] mixed;                  // Mixed decay armed per bridge
        logic [1:0] polar;                  // Current polarity per bridge
        sbp_pkg::sbp_phase_t [1:0] phase;   // Regulator phase per bridge
        logic [1:0][6:0] cnt;               // Cycle counters per bridge
        logic [1:0] sr_stop;                // Rectification stopped
        logic [1:0][3:0] gate;              // Registered gate drives
        logic [1:0][7:0] tref;              // Registered trip levels
        logic home;                         // Home flag
    } sbp_state_t;

    sbp_state_t state_reg;
    sbp_state_t state_next;

    // ==========================================================
    // Functions
    // ==========================================================
    // Sine magnitude for a quarter index 0..16, in percent
    function automatic logic [7:0] sbp_sine(input logic [4:0] q);
        logic [7:0] v;
        v = 8'h00;
        unique case (q)
            5'h00: v = 8'h00;
            5'h01: v = 8'h0a;
            5'h02: v = 8'h14;
            5'h03: v = 8'h1d;
            5'h04: v = 8'h26;
            5'h05: v = 8'h2f;
            5'h06: v = 8'h38;
            5'h07: v = 8'h40;
            5'h08: v = 8'h47;
            5'h09: v = 8'h4d;
            5'h0a: v = 8'h53;
            5'h0b: v = 8'h58;
            5'h0c: v = 8'h5c;
            5'h0d: v = 8'h5f;
            5'h0e: v = 8'h62;
            5'h0f: v = 8'h63;
            default: v = 8'h64;
        endcase
        return v;
    endfunction : sbp_sine

    // Percent magnitude of a bridge at index p (bridge 2 shifted 90 deg)
    function automatic logic [7:0] sbp_mag(input logic [5:0] p,
                                           input logic b);
        logic [5:0] a;
        logic [4:0] q;
        a = b ? p + 6'h10 : p;
        q = a[4] ? 5'h10 - {1'b0, a[3:0]} : {1'b0, a[3:0]};
        return sbp_sine(q);
    endfunction : sbp_mag

    // Polarity of a bridge at index p
    function automatic logic sbp_pol(input logic [5:0] p, input logic b);
        logic [5:0] a;
        a = b ? p + 6'h10 : p;
        return a[5];
    endfunction : sbp_pol

    // Trip level: reference / 8 scaled by percent
    function automatic logic [7:0] sbp_tref(input logic [7:0] r,
                                            input logic [7:0] pct);
        logic [15:0] m;
        // Widen both factors first; an 8-bit product would wrap
        m = {8'h00, r >> sbp_pkg::REF_DIV_SHIFT} * {8'h00, pct};
        return 8'(m / 16'h0064);
    endfunction : sbp_tref

    // ==========================================================
    // Gate patterns
    // ==========================================================
    // Bit map: [0] high A, [1] low A, [2] high B, [3] low B
    // Polarity 0 drives high A with low B (pattern 1001)
    // Polarity 1 drives high B with low A (pattern 0110)
    // Slow decay keeps only the sink of the driving pair
    // Slow decay with rectification adds the other low side
    // Fast decay drops both; rectification then turns on
    // the opposite diagonal so current returns to the supply
    // The caller holds rectification back for a dead time,
    // so no transistor meets its own leg partner too soon
    // Gate pattern for phase, polarity and decay kind
    function automatic logic [3:0] sbp_gates(input sbp_pkg::sbp_phase_t ph,
                                             input logic pol,
                                             input logic fast,
                                             input logic rect);
        logic [3:0] g;
        g = 4'h0;
        unique case (ph)
            sbp_pkg::SBP_BLANK, sbp_pkg::SBP_DRIVE: begin
                // Diagonal pair: high of one leg, low of the other
                g = pol ? 4'b0110 : 4'b1001;
            end
            sbp_pkg::SBP_OFF: begin
                if (fast) begin
                    // Both dropped; rectify through opposite diagonal
                    g = rect ? (pol ? 4'b1001 : 4'b0110) : 4'h0;
                end else begin
                    // Source dropped, sink kept; rectify other low side
                    // Sink is low A for polarity 1, low B for 0
                    g = pol ? (rect ? 4'b1010 : 4'b0010)
                            : (rect ? 4'b1010 : 4'b1000);
                end
            end
            default: g = 4'h0;
        endcase
        return g;
    endfunction : sbp_gates

    // ==========================================================
    // Next state
    // ==========================================================
    logic step_rise;        // Step edge
    logic [5:0] incr;       // Increment from resolution
    logic [6:0] fd_cyc;     // Fast portion length
    logic run;              // Regulation permitted
    logic [7:0] old_mag;    // Magnitude before step
    logic [7:0] new_mag;    // Magnitude after step
    logic fast_now;         // Current off cycle is in fast decay
    logic dz_win;           // Dead window where fast gives way to slow

    // ==========================================================
    // Combined next-state process
    // ==========================================================
    // Translator first, then per-bridge regulator and gates.
    // Gates follow the registered phase, so they lag by a clock.
    // Counters only move on oscillator ticks; between ticks
    // the phase and the count hold still unless run drops.
    always_comb begin
        state_next = state_reg;
        step_rise = step_i && !state_reg.step_d;
        old_mag = 8'h00;
        new_mag = 8'h00;
        fast_now = 1'b0;
        dz_win = 1'b0;
        state_next.step_d = step_i;
        // Resolution read only at the edge itself
        unique case ({microstep_res_sel_b_i, microstep_res_sel_a_i})
            2'b00: incr = 6'h10;
            2'b01: incr = 6'h08;
            2'b10: incr = 6'h04;
            default: incr = 6'h01;
        endcase
        unique case ({fast_decay_fraction_sel_b_i,
                      fast_decay_fraction_sel_a_i})
            2'b00: fd_cyc = sbp_pkg::FD_FRAC0;
            2'b01: fd_cyc = sbp_pkg::FD_FRAC1;
            2'b10: fd_cyc = sbp_pkg::FD_FRAC2;
            default: fd_cyc = sbp_pkg::FD_FRAC3;
        endcase
        // Faults and lockout stop the drive
        run = sleep_n_i && !over_temp_i && !gate_regulator_rail_low_i
              && !supply_low_lockout_i;

        // Translator, independent of output disable
        if (!sleep_n_i || supply_low_lockout_i) begin
            state_next.pos = sbp_pkg::HOME_POS;
            state_next.mixed = 2'b11;
            state_next.home = 1'b1;
        end else if (step_rise) begin
            state_next.pos = dir_i ? state_reg.pos - incr
                                   : state_reg.pos + incr;
            // Home flag tracks the index, also when stepped back
            state_next.home = (state_next.pos == sbp_pkg::HOME_POS);
            for (int b = 0; b < 2; b++) begin
                old_mag = sbp_mag(state_reg.pos, 1'(b));
                new_mag = sbp_mag(state_next.pos, 1'(b));
                // Falling, or rising just past a zero crossing
                state_next.mixed[b] = (new_mag < old_mag)
                    || (old_mag == 8'h00);
            end
        end

        for (int b = 0; b < 2; b++) begin
            state_next.polar[b] = sbp_pol(state_next.pos, 1'(b));
            state_next.tref[b] = sbp_tref(ref_level_i,
                sbp_mag(state_next.pos, 1'(b)));
            if (!run) begin
                state_next.phase[b] = sbp_pkg::SBP_IDLE;
                state_next.cnt[b] = 7'h00;
                state_next.sr_stop[b] = 1'b0;
            end else if (osc_tick_i) begin
                // Counts advance on oscillator cycles only
                state_next.cnt[b] = state_reg.cnt[b] + 7'h01;
                unique case (state_reg.phase[b])
                    sbp_pkg::SBP_IDLE: begin
                        state_next.phase[b] = sbp_pkg::SBP_DEAD;
                        state_next.cnt[b] = 7'h00;
                    end
                    sbp_pkg::SBP_DEAD: begin
                        if (state_reg.cnt[b] == sbp_pkg::DEAD_CYC - 7'h01)
                        begin
                            state_next.phase[b] = sbp_pkg::SBP_BLANK;
                            state_next.cnt[b] = 7'h00;
                        end
                    end
                    sbp_pkg::SBP_BLANK: begin
                        if (state_reg.cnt[b] == sbp_pkg::BLANK_CYC - 7'h01)
                        begin
                            state_next.phase[b] = sbp_pkg::SBP_DRIVE;
                            state_next.cnt[b] = 7'h00;
                        end
                    end
                    sbp_pkg::SBP_DRIVE: begin
                        state_next.cnt[b] = 7'h00;
                        if (current_shunt_trip_i[b]) begin
                            state_next.phase[b] = sbp_pkg::SBP_OFF;
                            state_next.sr_stop[b] = 1'b0;
                        end
                    end
                    sbp_pkg::SBP_OFF: begin
                        // Trips ignored here; drive resumes after off
                        if (state_reg.cnt[b] == sbp_pkg::OFF_CYC - 7'h01)
                        begin
                            state_next.phase[b] = sbp_pkg::SBP_DEAD;
                            state_next.cnt[b] = 7'h00;
                        end
                    end
                    default: state_next.phase[b] = sbp_pkg::SBP_IDLE;
                endcase
            end
            if (state_reg.phase[b] == sbp_pkg::SBP_OFF
                && zero_current_i[b]) begin
                state_next.sr_stop[b] = 1'b1;
            end
            // Fast while mixed and within the selected portion
            fast_now = state_reg.mixed[b] && fd_cyc != 7'h00
                && state_reg.cnt[b] < fd_cyc;
            // All off for a dead time where fast gives way to slow;
            // the fast rectifying high side shares a leg with the
            // slow rectifying low side
            dz_win = state_reg.mixed[b] && fd_cyc != 7'h00
                && state_reg.cnt[b] >= fd_cyc
                && state_reg.cnt[b] < fd_cyc + sbp_pkg::DEAD_CYC;
            if (out_disable_i || !run) begin
                // Forced off; sequencing keeps running under output disable only
                state_next.gate[b] = 4'h0;
            end else begin
                // Rectifiers wait one dead time into the off period
                state_next.gate[b] = sbp_gates(state_reg.phase[b],
                    state_reg.polar[b], fast_now || dz_win,
                    !sync_rectify_disable_i
                    && !state_reg.sr_stop[b]
                    && !dz_win
                    && state_reg.cnt[b] >= sbp_pkg::DEAD_CYC);
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Reset parks at home with both bridges idle and mixed armed.
    // Every gate is off in reset, so no drive leaks out early.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
            state_reg.pos <= sbp_pkg::HOME_POS;
            state_reg.mixed <= 2'b11;
            state_reg.home <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign gate1_o = state_reg.gate[0];
    assign gate2_o = state_reg.gate[1];
    assign trip_ref1_o = state_reg.tref[0];
    assign trip_ref2_o = state_reg.tref[1];
    assign position_o = state_reg.pos;
    assign home_o = state_reg.home;

endmodule : sbp_bridge_pwm

`default_nettype wire

// ### verification/sbp_bridge_pwm_asserts.sv
// Purpose: Port assertions for the bridge regulator.
// Assumes: Bound to sbp_bridge_pwm; faults force gates off.
// Notes: Dead time is checked on bridge 1 through an idle counter.
`default_nettype none
module sbp_bridge_pwm_asserts (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic sleep_n_i,
    input wire logic out_disable_i,
    input wire logic step_i,
    input wire logic over_temp_i,
    input wire logic gate_regulator_rail_low_i,
    input wire logic supply_low_lockout_i,
    input wire logic [3:0] gate1_o,
    input wire logic [3:0] gate2_o,
    input wire logic [5:0] position_o,
    input wire logic home_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    logic [7:0] idle_reg; // Clocks with bridge 1 idle, output disable and fault states excluded
    logic off_w; // Both bridges fully off
    logic dis_d_reg; // Output disable one clock back
    // Disable delayed, so a release does not look like a short idle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) dis_d_reg <= 1'b0;
        else dis_d_reg <= out_disable_i;
    end
    assign off_w = (gate1_o == 4'h0) && (gate2_o == 4'h0);
    // ==========================================================
    // Idle counter, cleared while bridge 1 gates are on or output disable or a fault forces them off
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) idle_reg <= 8'h00;
        else if (gate1_o != 4'h0 || out_disable_i || dis_d_reg ||
                 over_temp_i ||
                 gate_regulator_rail_low_i) idle_reg <= 8'h00;
        else if (idle_reg != 8'hff) idle_reg <= idle_reg + 8'h01;
    end
    gate_disable_a: assert property (out_disable_i |=> off_w)
        else $error("gates on while disabled");
    sleep_home_a: assert property (!sleep_n_i |=> off_w &&
        position_o == sbp_pkg::HOME_POS) else $error("sleep not home");
    fault_off_a: assert property (over_temp_i ||
        gate_regulator_rail_low_i |=> off_w) else $error("fault gates on");
    lockout_home_a: assert property (supply_low_lockout_i |=> off_w &&
        position_o == sbp_pkg::HOME_POS) else $error("lockout not home");
    home_flag_a: assert property (home_o ==
        (position_o == sbp_pkg::HOME_POS)) else $error("home flag wrong");
    step_moves_a: assert property ($rose(step_i) && sleep_n_i &&
        !supply_low_lockout_i |=> position_o != $past(position_o))
        else $error("step did not move");
    leg1_safe_a: assert property (!(gate1_o[0] && gate1_o[1]) &&
        !(gate1_o[2] && gate1_o[3])) else $error("bridge 1 shoot through");
    leg2_safe_a: assert property (!(gate2_o[0] && gate2_o[1]) &&
        !(gate2_o[2] && gate2_o[3])) else $error("bridge 2 shoot through");
    dead_time_a: assert property (gate1_o != 4'h0 && idle_reg != 8'h00
        |-> idle_reg >= 8'h14) else $error("dead time short");
    cover property (gate1_o != 4'h0 && idle_reg != 8'h00);
    cover property ($rose(step_i) && out_disable_i);
    cover property (over_temp_i ##1 off_w);
endmodule : sbp_bridge_pwm_asserts
bind sbp_bridge_pwm sbp_bridge_pwm_asserts u_sbp_bridge_pwm_asserts (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .sleep_n_i(sleep_n_i),
    .out_disable_i(out_disable_i), .step_i(step_i), .over_temp_i(over_temp_i),
    .gate_regulator_rail_low_i(gate_regulator_rail_low_i),
    .supply_low_lockout_i(supply_low_lockout_i), .gate1_o(gate1_o),
    .gate2_o(gate2_o), .position_o(position_o), .home_o(home_o));
`default_nettype wire

// ### verification/sbp_partner.sv
// Purpose: Bridges, windings and sense comparators behind the gates.
// Assumes: Current rises one unit per tick of diagonal drive.
// Notes: Trip level in ticks is set by rise_i; 0 trips at once.
`default_nettype none
module sbp_partner (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic osc_tick_i,
    input wire logic [3:0] gate1_i,
    input wire logic [3:0] gate2_i,
    input wire logic [7:0] rise_i,
    output logic [1:0] trip_o,
    output logic [1:0] zero_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] amp_reg [2]; // Winding current per bridge
    logic [3:0] g [2]; // Gates per bridge
    assign g[0] = gate1_i;
    assign g[1] = gate2_i;
    // Current grows under drive and decays otherwise
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        for (int i = 0; i < 2; i++) begin
            if (!nrst_i) amp_reg[i] <= 8'h00;
            else if (osc_tick_i && (g[i] == 4'h9 || g[i] == 4'h6))
                amp_reg[i] <= amp_reg[i] + {7'h00, amp_reg[i] != 8'hff};
            else if (osc_tick_i && amp_reg[i] != 8'h00)
                amp_reg[i] <= amp_reg[i] - 8'h01;
        end
    end
    // Comparators on shunt voltage and on zero current
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            trip_o[i] = amp_reg[i] >= rise_i;
            zero_o[i] = amp_reg[i] == 8'h00;
        end
    end
endmodule : sbp_partner
`default_nettype wire

// ### verification/tb_sbp_bridge_pwm.sv
// Purpose: Self-checking bench for the bridge regulator.
// Assumes: Oscillator tick every 10 clocks; inputs move at falling edge.
// Notes: Spans are measured in clocks, ten per oscillator cycle.
`default_nettype none
module tb_sbp_bridge_pwm;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0, nrst_i = 1'b0, tick = 1'b0, sleep_n = 1'b1;
    logic dis = 1'b0, step = 1'b0, dir = 1'b0, srd = 1'b1, ot = 1'b0;
    logic rail = 1'b0, lock = 1'b0, home;
    logic [1:0] ms = 2'h0, fd = 2'h0, trip, zero;
    logic [7:0] ref_lvl = 8'h80, rise = 8'h14, t1, t2;
    logic [3:0] g1, g2;
    logic [5:0] pos, exp_pos;
    int miscompares = 0, n_compared = 0, cyc = 0, tk = 0, seed = 94, n;
    sbp_bridge_pwm u_sbp_bridge_pwm (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .osc_tick_i(tick), .sleep_n_i(sleep_n), .out_disable_i(dis),
        .step_i(step), .dir_i(dir), .microstep_res_sel_a_i(ms[0]),
        .microstep_res_sel_b_i(ms[1]), .fast_decay_fraction_sel_a_i(fd[0]),
        .fast_decay_fraction_sel_b_i(fd[1]), .sync_rectify_disable_i(srd),
        .ref_level_i(ref_lvl), .current_shunt_trip_i(trip),
        .zero_current_i(zero), .over_temp_i(ot),
        .gate_regulator_rail_low_i(rail), .supply_low_lockout_i(lock),
        .gate1_o(g1), .gate2_o(g2), .trip_ref1_o(t1), .trip_ref2_o(t2),
        .position_o(pos), .home_o(home));
    sbp_partner u_sbp_partner (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .osc_tick_i(tick), .gate1_i(g1), .gate2_i(g2), .rise_i(rise),
        .trip_o(trip), .zero_o(zero));
    // ==========================================================
    // Clock, oscillator tick and hang limit
    initial forever #12.5 mclk_i = ~mclk_i;
    always @(negedge mclk_i) begin
        tk <= (tk == 9) ? 0 : tk + 1;
        tick <= (tk == 9);
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wt(input int k);
        repeat (k) @(negedge mclk_i);
    endtask : wt
    // Wait until bridge 1 drive state matches want; k is clocks spent
    task automatic wait_diag(input logic want, output int k);
        k = 0;
        while (((g1 === 4'h9) || (g1 === 4'h6)) !== want && k < 3000) begin
            @(negedge mclk_i);
            k++;
        end
        if (k >= 3000) check(16'h0, 16'h1);
    endtask : wait_diag
    function automatic logic inr(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction : inr
    function automatic logic [5:0] next_pos(input logic [5:0] p,
        input logic d, input logic [1:0] m);
        logic [5:0] inc;
        inc = (m == 2'h0) ? 6'h10 : (m == 2'h1) ? 6'h08 :
              (m == 2'h2) ? 6'h04 : 6'h01;
        return d ? p - inc : p + inc;
    endfunction : next_pos
    // Start a regulation cycle and stop at the trip drop
    task automatic to_drop(input logic [1:0] f, input logic s);
        fd = f;
        srd = s;
        wait_diag(1'b1, n);
        wait_diag(1'b0, n);
    endtask : to_drop
    task automatic complete_run();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // ==========================================================
    // Main sequence
    initial begin
        wt(6);
        nrst_i = 1'b1;
        wt(2);
        check(pos, 6'h08);
        check(home, 1'b1);
        sleep_n = 1'b0;
        wt(100);
        sleep_n = 1'b1;
        wt(40000);
        to_drop(2'h0, 1'b1);
        wt(30);
        check(g1 & 4'h5, 4'h0);
        check(16'($countones(g1)), 16'h1);
        wait_diag(1'b1, n);
        check(inr(n + 30, 895, 925), 1'b1);
        rise = 8'h00;
        wait_diag(1'b0, n);
        wait_diag(1'b1, n);
        wait_diag(1'b0, n);
        check(inr(n, 55, 75), 1'b1);
        wait_diag(1'b1, n);
        check(inr(n, 895, 925), 1'b1);
        rise = 8'h14;
        exp_pos = pos;
        for (int i = 0; i < 24; i++) begin
            dis = 1'($random(seed));
            dir = 1'($random(seed));
            ms = 2'($random(seed));
            ref_lvl = 8'($random(seed));
            step = 1'b1;
            wt(2);
            step = 1'b0;
            wt(2);
            exp_pos = next_pos(exp_pos, dir, ms);
            check(pos, exp_pos);
            check(t1 <= (ref_lvl >> 3), 1'b1);
            check(t2 <= (ref_lvl >> 3), 1'b1);
            if (pos[3:0] == 4'h0) check({t1, t2}, pos[4] ?
                {ref_lvl >> 3, 8'h00} : {8'h00, ref_lvl >> 3});
            if (dis) check({g1, g2}, 8'h00);
        end
        dis = 1'b0;
        sleep_n = 1'b0;
        wt(3);
        sleep_n = 1'b1;
        wt(2);
        check(pos, 6'h08);
        to_drop(2'h3, 1'b1);
        wt(30);
        check(g1, 4'h0);
        wt(400);
        check(g1, 4'h0);
        to_drop(2'h1, 1'b1);
        wt(30);
        check(g1, 4'h0);
        wt(300);
        check(16'($countones(g1)), 16'h1);
        to_drop(2'h0, 1'b0);
        wt(40);
        check(g1, 4'ha);
        wt(500);
        check(g1 === 4'ha, 1'b0);
        ot = 1'b1;
        wt(5);
        check({g1, g2}, 8'h00);
        ot = 1'b0;
        rail = 1'b1;
        wt(5);
        check({g1, g2}, 8'h00);
        rail = 1'b0;
        lock = 1'b1;
        wt(5);
        check({pos, g1}, {6'h08, 4'h0});
        lock = 1'b0;
        wait_diag(1'b1, n);
        check(n < 3000, 1'b1);
        complete_run();
    end
endmodule : tb_sbp_bridge_pwm
`default_nettype wire
